// File: verilog/cmp_ctrl_pkg.sv
// Package: register map, fields, reset values and timing of the comparator block
`default_nettype none
package cmp_ctrl_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] A_PROTECT = 8'h00;
    localparam logic [7:0] A_CH1_CTRL = 8'h04;
    localparam logic [7:0] A_CH2_CTRL = 8'h08;
    localparam logic [7:0] A_STATUS = 8'h0c;
    localparam logic [7:0] A_ENABLE = 8'h10;
    localparam logic [7:0] A_EDGE = 8'h14;
    localparam logic [7:0] A_BANDGAP = 8'h18;
    localparam logic [7:0] A_CONFIG = 8'h1c;
    localparam int B_PROTECT = 3;
    localparam int B_IRQ_EN = 0;
    localparam int B_FILT_DIS = 1;
    localparam int B_FLAG = 2;
    localparam int B_RESULT = 3;
    localparam int B_DIV = 4;
    localparam int B_DIR = 7;
    localparam int B_CH2_STATUS = 3;
    localparam int B_LOW_CONS = 0;
    localparam int B_MON0_EN = 5;
    localparam int B_CH_EN = 6;
    localparam int B_EDGE = 1;
    localparam int B_BG_DIS = 0;
    localparam int B_SHARED = 0;
    localparam int B_IRQ_TYPE = 1;
    localparam int B_REF_EXT = 3;
    localparam int B_INVERT = 5;
    localparam logic RST_FILT_DIS = 1'b1;
    localparam logic RST_STATUS = 1'b1;
    localparam int CLK_NS = 8;
    localparam int SETTLE_NS = 100000;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETTLE_W = 16;
    localparam int DIV_W = 4;
endpackage
`default_nettype wire

// File: verilog/cmp_ctrl.sv
// Dual comparator control: filters, edge detect, flags, pins and Avalon-MM registers
`default_nettype none
module cmp_ctrl #(
    parameter int SETTLE_CYCLES = cmp_ctrl_pkg::SETTLE_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_soft_rst,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_low_speed_osc_clock,
    input wire logic i_ch1_above_internal_ref,
    input wire logic i_ch1_above_external_ref,
    input wire logic i_ch2_above_internal_ref,
    input wire logic i_ch2_above_external_ref,
    output logic o_ch1_result_pin,
    output logic o_ch2_result_pin,
    output logic o_ch1_nmi,
    output logic o_ch1_irq,
    output logic o_ch2_nmi,
    output logic o_ch2_irq,
    output logic o_monitors_own_circuit,
    output logic o_monitor0_active,
    output logic o_bandgap_disable,
    output logic o_low_consumption_enable
);
    localparam int SW = cmp_ctrl_pkg::SETTLE_W;
    localparam int DW = cmp_ctrl_pkg::DIV_W;
    localparam logic [SW-1:0] SETTLE_LOAD = SW'(SETTLE_CYCLES);

    typedef struct packed {
        logic wait_r;
        logic [31:0] rdata;
        logic prot;
        logic shared;
        logic mon_own;
        logic low_cons;
        logic bg_dis;
        logic mon_en;
        logic mon_act;
        logic [SW-1:0] mon_cnt;
        logic osc_prev;
        logic [1:0] en;
        logic [1:0] act;
        logic [1:0] irq_en;
        logic [1:0] filt_dis;
        logic [1:0] flag;
        logic [1:0] status;
        logic [1:0] dir;
        logic [1:0] edge2;
        logic [1:0] irq_type;
        logic [1:0] ref_ext;
        logic [1:0] inv;
        logic [1:0] smp;
        logic [1:0] filt;
        logic [1:0] prev;
        logic [1:0] pin;
        logic [1:0] nmi;
        logic [1:0] irq;
        logic [1:0][1:0] div;
        logic [1:0][DW-1:0] dcnt;
        logic [1:0][SW-1:0] cnt;
    } st_t;

    st_t r;
    st_t n;
    logic wr_ok;
    logic rd_go;
    logic osc_tick;
    logic [1:0] raw;
    logic [1:0] cur;
    logic [1:0] ev;
    logic [1:0] tick;
    logic [31:0] rv;

    function automatic logic [DW-1:0] div_last(input logic [1:0] sel);
        div_last = DW'((4'h2 << sel) - 4'h1);
    endfunction

    function automatic logic [31:0] ctrl_img(input st_t s, input int c);
        ctrl_img = '0;
        ctrl_img[cmp_ctrl_pkg::B_IRQ_EN] = s.irq_en[c];
        ctrl_img[cmp_ctrl_pkg::B_FILT_DIS] = s.filt_dis[c];
        ctrl_img[cmp_ctrl_pkg::B_FLAG] = s.flag[c];
        ctrl_img[cmp_ctrl_pkg::B_RESULT] = s.status[c];
        ctrl_img[cmp_ctrl_pkg::B_DIV +: 2] = s.div[c];
        ctrl_img[cmp_ctrl_pkg::B_DIR] = s.dir[c];
    endfunction

    assign wr_ok = i_avs_write & ~r.wait_r;
    assign rd_go = i_avs_read & r.wait_r;
    assign osc_tick = i_low_speed_osc_clock & ~r.osc_prev;
    assign raw[0] = r.ref_ext[0] ? i_ch1_above_external_ref : i_ch1_above_internal_ref;
    assign raw[1] = r.ref_ext[1] ? i_ch2_above_external_ref : i_ch2_above_internal_ref;

    always_comb begin
        n = r;
        cur = '0;
        ev = '0;
        tick = '0;
        rv = '0;
        // One wait cycle, then a single accepted cycle
        n.wait_r = ~((i_avs_read | i_avs_write) & r.wait_r);
        n.osc_prev = i_low_speed_osc_clock;
        n.nmi = '0;
        n.irq = '0;
        if (!r.mon_en) begin
            n.mon_act = 1'b0;
        end else if (!r.mon_act) begin
            if (r.mon_cnt == '0) begin
                n.mon_act = 1'b1;
            end else begin
                n.mon_cnt = r.mon_cnt - 1'b1;
            end
        end
        // Each channel touches only its own index
        for (int i = 0; i < 2; i++) begin
            tick[i] = osc_tick & (r.dcnt[i] == div_last(r.div[i]));
            if (osc_tick) begin
                n.dcnt[i] = tick[i] ? '0 : r.dcnt[i] + 1'b1;
            end
            if (tick[i]) begin
                n.smp[i] = raw[i];
                if (r.smp[i] == raw[i]) begin
                    n.filt[i] = raw[i];
                end
            end
            cur[i] = r.filt_dis[i] ? raw[i] : r.filt[i];
            n.prev[i] = cur[i];
            if (r.act[i] & r.shared) begin
                if (r.edge2[i]) begin
                    ev[i] = cur[i] ^ r.prev[i];
                end else if (r.dir[i]) begin
                    ev[i] = ~cur[i] & r.prev[i];
                end else begin
                    ev[i] = cur[i] & ~r.prev[i];
                end
            end
            if (r.en[i] & r.act[i] & r.shared) begin
                n.status[i] = cur[i];
            end else if (i == 1 && !r.en[i]) begin
                n.status[i] = 1'b1;
            end
            if (!r.en[i]) begin
                n.act[i] = 1'b0;
            end else if (!r.act[i]) begin
                if (r.cnt[i] == '0) begin
                    n.act[i] = 1'b1;
                end else begin
                    n.cnt[i] = r.cnt[i] - 1'b1;
                end
            end
        end
        if (wr_ok) begin
            case (i_avs_address)
                cmp_ctrl_pkg::A_PROTECT: begin
                    n.prot = i_avs_writedata[cmp_ctrl_pkg::B_PROTECT];
                end
                cmp_ctrl_pkg::A_CH1_CTRL, cmp_ctrl_pkg::A_CH2_CTRL: begin
                    if (r.prot) begin
                        for (int i = 0; i < 2; i++) begin
                            if ((i == 1) == (i_avs_address == cmp_ctrl_pkg::A_CH2_CTRL)) begin
                                n.irq_en[i] = i_avs_writedata[cmp_ctrl_pkg::B_IRQ_EN];
                                n.filt_dis[i] = i_avs_writedata[cmp_ctrl_pkg::B_FILT_DIS];
                                // Zero clears; a one keeps the flag as it is
                                n.flag[i] = r.flag[i] & i_avs_writedata[cmp_ctrl_pkg::B_FLAG];
                                n.div[i] = i_avs_writedata[cmp_ctrl_pkg::B_DIV +: 2];
                                if (!r.edge2[i]) begin
                                    n.dir[i] = i_avs_writedata[cmp_ctrl_pkg::B_DIR];
                                end
                            end
                        end
                    end
                end
                cmp_ctrl_pkg::A_ENABLE: begin
                    if (r.prot) begin
                        n.low_cons = i_avs_writedata[cmp_ctrl_pkg::B_LOW_CONS];
                        n.mon_en = i_avs_writedata[cmp_ctrl_pkg::B_MON0_EN];
                        if (n.mon_en & ~r.mon_en) begin
                            n.mon_cnt = SETTLE_LOAD;
                            n.mon_act = 1'b0;
                        end
                        for (int i = 0; i < 2; i++) begin
                            n.en[i] = i_avs_writedata[cmp_ctrl_pkg::B_CH_EN + i];
                            if (n.en[i] & ~r.en[i]) begin
                                n.cnt[i] = SETTLE_LOAD;
                                n.act[i] = 1'b0;
                            end else if (!n.en[i]) begin
                                n.act[i] = 1'b0;
                            end
                        end
                    end
                end
                cmp_ctrl_pkg::A_EDGE: begin
                    n.edge2 = i_avs_writedata[cmp_ctrl_pkg::B_EDGE +: 2];
                end
                cmp_ctrl_pkg::A_BANDGAP: begin
                    if (r.prot) begin
                        n.bg_dis = i_avs_writedata[cmp_ctrl_pkg::B_BG_DIS];
                    end
                end
                cmp_ctrl_pkg::A_CONFIG: begin
                    n.shared = i_avs_writedata[cmp_ctrl_pkg::B_SHARED];
                    n.irq_type = i_avs_writedata[cmp_ctrl_pkg::B_IRQ_TYPE +: 2];
                    n.ref_ext = i_avs_writedata[cmp_ctrl_pkg::B_REF_EXT +: 2];
                    n.inv = i_avs_writedata[cmp_ctrl_pkg::B_INVERT +: 2];
                end
                default: begin
                end
            endcase
        end
        for (int i = 0; i < 2; i++) begin
            // Control writes never set the flag by themselves here
            n.flag[i] = n.flag[i] | ev[i];
            n.nmi[i] = ev[i] & r.en[i] & r.irq_en[i] & ~r.irq_type[i];
            n.irq[i] = ev[i] & r.en[i] & r.irq_en[i] & r.irq_type[i];
        end
        case (i_avs_address)
            cmp_ctrl_pkg::A_PROTECT: rv[cmp_ctrl_pkg::B_PROTECT] = r.prot;
            cmp_ctrl_pkg::A_CH1_CTRL: rv = ctrl_img(r, 0);
            cmp_ctrl_pkg::A_CH2_CTRL: rv = ctrl_img(r, 1);
            cmp_ctrl_pkg::A_STATUS: rv[cmp_ctrl_pkg::B_CH2_STATUS] = r.status[1];
            cmp_ctrl_pkg::A_ENABLE: begin
                rv[cmp_ctrl_pkg::B_LOW_CONS] = r.low_cons;
                rv[cmp_ctrl_pkg::B_MON0_EN] = r.mon_en;
                rv[cmp_ctrl_pkg::B_CH_EN +: 2] = r.en;
            end
            cmp_ctrl_pkg::A_EDGE: rv[cmp_ctrl_pkg::B_EDGE +: 2] = r.edge2;
            cmp_ctrl_pkg::A_BANDGAP: rv[cmp_ctrl_pkg::B_BG_DIS] = r.bg_dis;
            cmp_ctrl_pkg::A_CONFIG: begin
                rv[cmp_ctrl_pkg::B_SHARED] = r.shared;
                rv[cmp_ctrl_pkg::B_IRQ_TYPE +: 2] = r.irq_type;
                rv[cmp_ctrl_pkg::B_REF_EXT +: 2] = r.ref_ext;
                rv[cmp_ctrl_pkg::B_INVERT +: 2] = r.inv;
            end
            default: rv = '0;
        endcase
        if (rd_go) begin
            n.rdata = rv;
        end
        // Flags, status and the enable register outlive this reset
        if (i_soft_rst) begin
            n.prot = 1'b0;
            n.shared = 1'b0;
            n.bg_dis = 1'b0;
            n.irq_en = '0;
            n.filt_dis = {2{cmp_ctrl_pkg::RST_FILT_DIS}};
            n.dir = '0;
            n.edge2 = '0;
            n.irq_type = '0;
            n.ref_ext = '0;
            n.inv = '0;
            n.div = '0;
            n.dcnt = '0;
            n.nmi = '0;
            n.irq = '0;
        end
        for (int i = 0; i < 2; i++) begin
            n.pin[i] = n.status[i] ^ n.inv[i];
        end
        // Registered so the owner output is a flop like the other pins
        n.mon_own = ~n.shared;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            r <= '0;
            r.wait_r <= 1'b1;
            r.filt_dis <= {2{cmp_ctrl_pkg::RST_FILT_DIS}};
            r.status <= {2{cmp_ctrl_pkg::RST_STATUS}};
            // Pins start at status xor no inversion, monitors own the detector
            r.pin <= {2{cmp_ctrl_pkg::RST_STATUS}};
            r.mon_own <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign o_avs_readdata = r.rdata;
    assign o_avs_waitrequest = r.wait_r;
    assign o_ch1_result_pin = r.pin[0];
    assign o_ch2_result_pin = r.pin[1];
    assign o_ch1_nmi = r.nmi[0];
    assign o_ch1_irq = r.irq[0];
    assign o_ch2_nmi = r.nmi[1];
    assign o_ch2_irq = r.irq[1];
    assign o_monitors_own_circuit = r.mon_own;
    assign o_monitor0_active = r.mon_act;
    assign o_bandgap_disable = r.bg_dis;
    assign o_low_consumption_enable = r.low_cons;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    a_bus_one_wait:
        assert property ((i_avs_read | i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("bus request not answered after one wait cycle");
    a_flag_clear_only:
        assert property ($fell(r.flag[0]) |-> $past(wr_ok && r.prot
            && i_avs_address == cmp_ctrl_pkg::A_CH1_CTRL
            && !i_avs_writedata[cmp_ctrl_pkg::B_FLAG]))
        else $error("flag fell without a zero write");
    a_flag_on_event:
        assert property (ev[1] |=> r.flag[1])
        else $error("crossing did not set the flag");
    a_ch2_off_one:
        assert property (!r.en[1] |=> r.status[1])
        else $error("disabled channel 2 status not one");
    a_settle_hold:
        assert property ($rose(r.en[0]) |-> !r.act[0] [*8])
        else $error("channel active before settle delay");
    a_settle_done:
        assert property (r.en[0] && !r.act[0] && r.cnt[0] == '0 |=> r.act[0] || !r.en[0])
        else $error("channel not active after settle count");
    a_protect_guard:
        assert property (wr_ok && i_avs_address == cmp_ctrl_pkg::A_ENABLE && !r.prot
            |=> r.en == $past(r.en))
        else $error("enable changed while protected");
    a_nmi_type:
        assert property (r.nmi[0] |-> $past(!r.irq_type[0] && r.en[0] && r.irq_en[0]))
        else $error("non-maskable request with wrong type");
    a_route_monitors:
        assert property (!r.shared |-> ev == 2'b00)
        else $error("event while monitors own detector");
    a_rise_only:
        assert property (ev[0] && !r.edge2[0] && !r.dir[0] |-> cur[0] && !r.prev[0])
        else $error("rising select fired on other edge");
    a_filter_agree:
        assert property ($changed(r.filt[0]) |-> r.smp[0] == r.filt[0] && $past(tick[0]))
        else $error("filter changed without agreeing samples");
    a_pin_invert:
        assert property (o_ch2_result_pin == (r.status[1] ^ r.inv[1]))
        else $error("result pin polarity wrong");
    a_irq_needs_en:
        assert property (r.irq[0] |-> $past(r.irq_type[0] && r.en[0] && r.irq_en[0]))
        else $error("maskable request without enable");
    a_soft_keep:
        assert property (i_soft_rst && !wr_ok |=> r.en == $past(r.en) && !$fell(r.flag[0]))
        else $error("soft reset changed enables or flag");
endmodule
`default_nettype wire

// File: verif/cmp_far_side.sv
// Far-side model: comparator outputs, slow oscillator, interrupt request counters
`default_nettype none
module cmp_far_side #(
    parameter logic [7:0] VREF = 8'h80
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_osc_run,
    input wire logic [7:0] i_vin1,
    input wire logic [7:0] i_vin2,
    input wire logic [7:0] i_vext,
    input wire logic [3:0] i_req,
    output logic o_osc,
    output logic [3:0] o_above,
    output logic [3:0][7:0] o_cnt
);
    logic [2:0] div_reg;
    // Oscillator halts when told, so the filter then sees no sample edges
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            div_reg <= 3'h0;
        end else if (i_osc_run) begin
            div_reg <= div_reg + 3'h1;
        end
    end
    assign o_osc = div_reg[2];
    // Order: ch1 internal, ch1 external, ch2 internal, ch2 external
    assign o_above = {i_vin2 >= i_vext, i_vin2 >= VREF, i_vin1 >= i_vext, i_vin1 >= VREF};
    // Order: ch1 nmi, ch1 maskable, ch2 nmi, ch2 maskable
    always_ff @(posedge i_clk) begin
        for (int k = 0; k < 4; k++) begin
            if (i_rst) begin
                o_cnt[k] <= 8'h0;
            end else if (i_req[k]) begin
                o_cnt[k] <= o_cnt[k] + 8'h1;
            end
        end
    end
endmodule
`default_nettype wire

// File: verif/dual_comparator_control_bench.sv
// Self-checking bench for the dual comparator control block
`default_nettype none
module dual_comparator_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ST = 10;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } row_t;
    logic clk = 1'b0, rst = 1'b1, srst = 1'b0, rd = 1'b0, we = 1'b0, osc_run = 1'b0;
    logic [7:0] adr = 8'h0, vin1 = 8'h0, vin2 = 8'h0, vext = 8'hff;
    logic [31:0] wd = 32'h0, rdata, q;
    logic wreq, osc, pin1, pin2, nmi1, irq1, nmi2, irq2, mon_own, mon_act, bgdis, lowc;
    logic [3:0] above;
    logic [3:0][7:0] cnt;
    int n_errors = 0, checks = 0;
    row_t rows [7] = '{'{8'h14, 32'h06, 32'h06}, '{8'h14, 32'h00, 32'h00},
        '{8'h18, 32'h01, 32'h01}, '{8'h18, 32'h00, 32'h00}, '{8'h20, 32'hff, 32'h00},
        '{8'h1c, 32'h7f, 32'h7f}, '{8'h1c, 32'h01, 32'h01}};
    always #4 clk = ~clk;
    cmp_ctrl #(.SETTLE_CYCLES(ST)) dut (.i_clk(clk), .i_rst(rst), .i_soft_rst(srst),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(we), .i_avs_writedata(wd),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_low_speed_osc_clock(osc),
        .i_ch1_above_internal_ref(above[0]), .i_ch1_above_external_ref(above[1]),
        .i_ch2_above_internal_ref(above[2]), .i_ch2_above_external_ref(above[3]),
        .o_ch1_result_pin(pin1), .o_ch2_result_pin(pin2), .o_ch1_nmi(nmi1),
        .o_ch1_irq(irq1), .o_ch2_nmi(nmi2), .o_ch2_irq(irq2),
        .o_monitors_own_circuit(mon_own), .o_monitor0_active(mon_act),
        .o_bandgap_disable(bgdis), .o_low_consumption_enable(lowc));
    cmp_far_side far (.i_clk(clk), .i_rst(rst), .i_osc_run(osc_run), .i_vin1(vin1),
        .i_vin2(vin2), .i_vext(vext), .i_req({irq2, nmi2, irq1, nmi1}), .o_osc(osc),
        .o_above(above), .o_cnt(cnt));
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
    endtask
    // Request held until the edge that samples waitrequest low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w;
        we <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        q = rdata;
        rd <= 1'b0;
        we <= 1'b0;
        if (wreq !== 1'b0) begin
            n_errors++;
            stop_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask
    task automatic waitc(input int i, input logic [7:0] e, input string nm);
        int n;
        for (n = 0; n < 100 && cnt[i] !== e; n++) @(posedge clk);
        chk(nm, {24'h0, e}, {24'h0, cnt[i]});
    endtask
    task automatic hw_reset();
        rst <= 1'b1;
        tick(5);
        rst <= 1'b0;
    endtask
    initial begin
        int n;
        hw_reset();
        chk("pin1", 32'h1, {31'h0, pin1});
        rchk(8'h04, 32'h0a, "ch1 ctrl");
        rchk(8'h0c, 32'h08, "status");
        wr(8'h00, 32'h08);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rchk(rows[i].a, rows[i].e, "row");
        end
        // Guarded write must be dropped while protection is on
        wr(8'h00, 32'h00);
        wr(8'h18, 32'h01);
        rchk(8'h18, 32'h00, "bandgap");
        wr(8'h10, 32'hc1);
        rchk(8'h10, 32'h00, "enable guarded");
        wr(8'h00, 32'h08);
        // Detectors all off, so the band-gap may be switched off
        wr(8'h18, 32'h01);
        tick(1);
        chk("bandgap out", 32'h1, {31'h0, bgdis});
        wr(8'h18, 32'h00);
        wr(8'h10, 32'hc1);
        wr(8'h04, 32'h03);
        wr(8'h08, 32'h03);
        tick(ST + 5);
        chk("pin1 low", 32'h0, {31'h0, pin1});
        chk("low cons", 32'h1, {31'h0, lowc});
        vin1 <= 8'hc0;
        waitc(0, 8'h1, "nmi1");
        chk("nmi2", 32'h0, {24'h0, cnt[2]});
        chk("pin1 high", 32'h1, {31'h0, pin1});
        rchk(8'h04, 32'h0f, "flag set");
        wr(8'h04, 32'h07);
        rchk(8'h04, 32'h0f, "flag keep");
        wr(8'h04, 32'h03);
        rchk(8'h04, 32'h0b, "flag clear");
        vin1 <= 8'h00;
        tick(10);
        chk("no fall", 32'h1, {24'h0, cnt[0]});
        wr(8'h04, 32'h83);
        vin1 <= 8'hc0;
        tick(10);
        chk("no rise", 32'h1, {24'h0, cnt[0]});
        vin1 <= 8'h00;
        waitc(0, 8'h2, "fall");
        wr(8'h14, 32'h02);
        vin1 <= 8'hc0;
        waitc(0, 8'h3, "both rise");
        vin1 <= 8'h00;
        waitc(0, 8'h4, "both fall");
        wr(8'h04, 32'h03);
        rchk(8'h04, 32'h83, "dir held");
        wr(8'h14, 32'h00);
        wr(8'h04, 32'h03);
        vext <= 8'h40;
        wr(8'h1c, 32'h2b);
        vin1 <= 8'h60;
        waitc(1, 8'h1, "irq1 ext");
        chk("nmi1 idle", 32'h4, {24'h0, cnt[0]});
        chk("pin1 inv", 32'h0, {31'h0, pin1});
        vin2 <= 8'hc0;
        waitc(2, 8'h1, "nmi2");
        chk("ch1 idle", 32'h4, {24'h0, cnt[0]});
        vin2 <= 8'h00;
        tick(5);
        rchk(8'h0c, 32'h00, "status2");
        wr(8'h08, 32'h02);
        wr(8'h10, 32'h60);
        for (n = 0; n < 50 && mon_act !== 1'b1; n++) @(posedge clk);
        chk("settle", 32'h1, {31'h0, n >= ST});
        rchk(8'h0c, 32'h08, "status2 off");
        chk("pin2", 32'h1, {31'h0, pin2});
        wr(8'h1c, 32'h2a);
        tick(1);
        chk("monitors", 32'h1, {31'h0, mon_own});
        vin1 <= 8'h00;
        tick(5);
        vin1 <= 8'h60;
        tick(10);
        chk("unselected", 32'h1, {24'h0, cnt[1]});
        wr(8'h1c, 32'h2b);
        vin1 <= 8'h00;
        tick(5);
        vin1 <= 8'h60;
        waitc(1, 8'h2, "irq1 again");
        srst <= 1'b1;
        tick(2);
        srst <= 1'b0;
        rchk(8'h04, 32'h0e, "soft keep");
        rchk(8'h00, 32'h00, "soft prot");
        rchk(8'h10, 32'h60, "soft enable");
        // Prime the filter with the osc running before requests are allowed
        wr(8'h00, 32'h08);
        wr(8'h1c, 32'h01);
        wr(8'h04, 32'h00);
        osc_run <= 1'b1;
        tick(100);
        osc_run <= 1'b0;
        wr(8'h04, 32'h11);
        vin1 <= 8'hc0;
        tick(40);
        chk("no osc", 32'h4, {24'h0, cnt[0]});
        osc_run <= 1'b1;
        waitc(0, 8'h5, "filtered");
        wr(8'h04, 32'h01);
        wr(8'h04, 32'h03);
        rchk(8'h04, 32'h0b, "filt rewrite");
        hw_reset();
        rchk(8'h04, 32'h0a, "hw reset");
        stop_test();
    end
endmodule
`default_nettype wire
